// *** src/crc_pkg.sv ***
// Constants, field layout and bus carrier for the CRC generator
package crc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int BITS_W = 6;

  // Register bases (address bits 5:4) and alias codes (address bits 3:2)
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_TAPS = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;
  localparam logic [1:0] SEL_RESULT = 2'h3;
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  localparam logic [ADDR_W-1:0] MAP_TOP = 8'h3f;

  // Control field positions
  localparam int WIDTH_HI = 28;
  localparam int WIDTH_LO = 24;
  localparam int POLY_LENGTH_MINUS_ONE_HI = 20;
  localparam int POLY_LENGTH_MINUS_ONE_LO = 16;
  localparam int ON_BIT = 15;
  localparam int HALT_IN_IDLE_BIT = 13;
  localparam int VCNT_HI = 12;
  localparam int VCNT_LO = 8;
  localparam int FULL_BIT = 7;
  localparam int EMPTY_BIT = 6;
  localparam int ISEL_BIT = 5;
  localparam int GO_BIT = 4;
  localparam int LSB_BIT = 3;
  localparam int MODE_BIT = 2;

  localparam logic [31:0] CONTROL_WMASK = 32'h1f1f_a03c;
  localparam logic [31:0] TAPS_WMASK = 32'hffff_fffe;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [4:0] LEN_TOP = 5'h1f;

  // Queue capacity by word width
  localparam logic [4:0] WIDTH_NARROW_MAX = 5'h07;
  localparam logic [4:0] WIDTH_MID_MAX = 5'h0f;
  localparam logic [CNT_W-1:0] CAP_NARROW = 5'h10;
  localparam logic [CNT_W-1:0] CAP_MID = 5'h08;
  localparam logic [CNT_W-1:0] CAP_WIDE = 5'h04;

  typedef enum {SH_IDLE, SH_SHIFT} shift_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;
endpackage

// *** src/programmable_crc_generator.sv ***
// Programmable CRC generator with word queue and Avalon-MM slave
`timescale 1ns/1ps
module programmable_crc_generator (
  input wire logic ref_clk,
  input wire logic reset,
  input crc_pkg::avs_req_t avs_req,
  output logic [crc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic idle_mode,
  output logic crc_irq
);
  import crc_pkg::*;

  function automatic logic [31:0] alias_apply(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be, input logic [1:0] kind);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wd;
    case (kind)
      ALIAS_CLR: alias_apply = old & ~m;
      ALIAS_SET: alias_apply = old | m;
      ALIAS_INV: alias_apply = old ^ m;
      default: alias_apply = (old & ~m) | m;
    endcase
    if (kind == ALIAS_BASE) begin
      alias_apply = (old & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}},
        {8{be[0]}}}) | m;
    end
  endfunction

  function automatic logic [CNT_W-1:0] fifo_cap(input logic [4:0] wm1);
    if (wm1 <= WIDTH_NARROW_MAX) begin
      fifo_cap = CAP_NARROW;
    end else if (wm1 <= WIDTH_MID_MAX) begin
      fifo_cap = CAP_MID;
    end else begin
      fifo_cap = CAP_WIDE;
    end
  endfunction

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] control_q;
  logic [31:0] taps_q;
  logic [31:0] data_q;
  logic [31:0] result_q;
  logic [31:0] fifo_mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [31:0] shift_q;
  logic [BITS_W-1:0] bits_q;
  shift_state_t state_q;
  logic cond_q;
  logic irq_q;

  // Bus decode
  wire req = avs_req.read | avs_req.write;
  wire ack_d = req & ~ack_q;
  wire wr_en = avs_req.write & ack_q;
  wire rd_take = avs_req.read & ~ack_q;
  wire in_range = avs_req.address <= MAP_TOP;
  wire [1:0] sel_reg = avs_req.address[5:4];
  wire [1:0] sel_alias = avs_req.address[3:2];
  wire wr_control = wr_en & in_range & (sel_reg == SEL_CONTROL);
  wire wr_taps = wr_en & in_range & (sel_reg == SEL_TAPS);
  wire wr_data = wr_en & in_range & (sel_reg == SEL_DATA);
  wire wr_result = wr_en & in_range & (sel_reg == SEL_RESULT);

  // Control fields
  wire [4:0] wm1 = control_q[WIDTH_HI:WIDTH_LO];
  wire [4:0] plm1 = control_q[POLY_LENGTH_MINUS_ONE_HI:POLY_LENGTH_MINUS_ONE_LO];
  wire on = control_q[ON_BIT];
  wire halt_in_idle = control_q[HALT_IN_IDLE_BIT];
  wire isel = control_q[ISEL_BIT];
  wire go = control_q[GO_BIT];
  wire lsb_first = control_q[LSB_BIT];
  wire alt_mode = control_q[MODE_BIT];
  // Module runs only when enabled, started and not halted by idle
  wire run = on & go & ~(halt_in_idle & idle_mode);

  // Queue status
  wire [CNT_W-1:0] cap = fifo_cap(wm1);
  wire full = count_q >= cap;
  wire empty = count_q == '0;
  wire push = wr_data & (sel_alias == ALIAS_BASE) & ~full & on;
  wire pop = run & (state_q == SH_IDLE) & ~empty;
  wire step = run & (state_q == SH_SHIFT);
  wire abort = (state_q == SH_SHIFT) & ~(on & go);

  // One CRC step
  wire in_bit = lsb_first ? shift_q[0] : shift_q[wm1];
  wire crc_msb = result_q[plm1];
  wire [31:0] len_mask = ALL_ONES >> (LEN_TOP - plm1);
  // Legacy mixes data into feedback, alternate shifts data in augmented
  wire fb = alt_mode ? crc_msb : (in_bit ^ crc_msb);
  wire in_low = alt_mode ? in_bit : fb;
  wire [31:0] crc_shl = {result_q[30:0], in_low};
  wire [31:0] tap_mix = fb ? taps_q : '0;
  wire [31:0] crc_next = (crc_shl ^ tap_mix) & len_mask;
  wire [31:0] shift_next = lsb_first ? {1'b0, shift_q[31:1]} :
    {shift_q[30:0], 1'b0};

  // Interrupt condition
  wire shift_done = empty & (state_q == SH_IDLE);
  wire cond_raw = isel ? empty : shift_done;
  wire cond_now = on & go & cond_raw;

  // Count update
  wire [CNT_W-1:0] count_d = count_q + CNT_W'(push) - CNT_W'(pop);

  // Register read view
  wire [31:0] control_rd = {3'b000, control_q[WIDTH_HI:WIDTH_LO], 3'b000,
    control_q[POLY_LENGTH_MINUS_ONE_HI:POLY_LENGTH_MINUS_ONE_LO], on, 1'b0, halt_in_idle, count_q, full, empty,
    isel, go, lsb_first, alt_mode, 2'b00};
  wire [31:0] rd_mux = (sel_reg == SEL_CONTROL) ? control_rd :
    (sel_reg == SEL_TAPS) ? taps_q :
    (sel_reg == SEL_DATA) ? data_q : result_q;
  wire [31:0] rdata_d = in_range ? rd_mux : '0;

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;
  assign crc_irq = irq_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= REG_RESET;
    end else begin
      ack_q <= ack_d;
      if (rd_take) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Software-written registers with alias handling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      control_q <= REG_RESET;
      taps_q <= REG_RESET;
      data_q <= REG_RESET;
    end else begin
      if (wr_control) begin
        control_q <= alias_apply(control_q, avs_req.writedata,
          avs_req.byteenable, sel_alias) & CONTROL_WMASK;
      end
      if (wr_taps) begin
        taps_q <= alias_apply(taps_q, avs_req.writedata,
          avs_req.byteenable, sel_alias) & TAPS_WMASK;
      end
      if (wr_data) begin
        data_q <= alias_apply(data_q, avs_req.writedata,
          avs_req.byteenable, sel_alias);
      end
    end
  end

  // Result: hardware step wins over a software write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_q <= REG_RESET;
    end else if (step) begin
      result_q <= crc_next;
    end else if (wr_result) begin
      result_q <= alias_apply(result_q, avs_req.writedata,
        avs_req.byteenable, sel_alias);
    end
  end

  // Word queue
  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem_q[wr_ptr_q] <= avs_req.writedata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(push);
      rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
      count_q <= count_d;
    end
  end

  // Serial shifter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= SH_IDLE;
      shift_q <= REG_RESET;
      bits_q <= '0;
    end else begin
      case (state_q)
        SH_IDLE: begin
          if (pop) begin
            state_q <= SH_SHIFT;
            shift_q <= fifo_mem_q[rd_ptr_q];
            bits_q <= BITS_W'(wm1) + BITS_W'(1);
          end
        end
        SH_SHIFT: begin
          if (abort) begin
            state_q <= SH_IDLE;
            bits_q <= '0;
          end else if (run) begin
            shift_q <= shift_next;
            bits_q <= bits_q - BITS_W'(1);
            if (bits_q == BITS_W'(1)) begin
              state_q <= SH_IDLE;
            end
          end
        end
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  // Interrupt pulse on the selected condition becoming true
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cond_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cond_q <= cond_now;
      irq_q <= cond_now & ~cond_q;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  wait_ans_a: assert property (avs_req.read && !ack_q |=>
    !avs_waitrequest && avs_readdata == $past(rdata_d))
    else $error("read answer not on second edge");
  empty_flag_a: assert property (
    pop && !push && count_q == 5'h01 |=>
    control_rd[EMPTY_BIT] && count_q == '0)
    else $error("empty flag missing after last pop");
  pop_dec_a: assert property (pop && !push |=>
    count_q == $past(count_q) - 5'h01)
    else $error("count not decremented on pop");
  full_hold_a: assert property (full && !pop && wr_data |=>
    count_q == $past(count_q))
    else $error("write accepted while full");
  abort_stop_a: assert property (abort |=>
    state_q == SH_IDLE && bits_q == '0)
    else $error("clearing start did not abort");
  halt_idle_a: assert property (
    state_q == SH_SHIFT && on && go && halt_in_idle && idle_mode && !wr_en
    |=> $stable(result_q) && $stable(bits_q))
    else $error("shifter ran while halted in idle");
  shift_len_a: assert property (pop && !wr_control |=>
    bits_q == BITS_W'($past(wm1)) + BITS_W'(1))
    else $error("bit count not width of word");
  lsb_shift_a: assert property (
    step && lsb_first && bits_q != BITS_W'(1) && !wr_control
    |=> shift_q == {1'b0, $past(shift_q[31:1])})
    else $error("lsb first shift wrong");
  taps_zero_a: assert property (wr_taps |=> !taps_q[0])
    else $error("tap bit zero not zero");
  irq_once_a: assert property (crc_irq |=> !crc_irq)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (crc_irq |-> $past(cond_now) &&
    !$past(cond_now, 2))
    else $error("interrupt without its condition");

  push_inc_a: assert property (push && !pop |=>
    count_q == $past(count_q) + 5'h01)
    else $error("count not incremented on push");
  cap_bound_a: assert property (count_q <= CAP_NARROW)
    else $error("count above largest capacity");
  cap_wide_a: assert property (
    wm1 > WIDTH_MID_MAX && count_q >= CAP_WIDE |-> !push)
    else $error("wide word queue over four");
  full_flag_a: assert property (count_q == cap |->
    control_rd[FULL_BIT])
    else $error("full flag clear at capacity");
  off_still_a: assert property (!on |-> !pop && !step)
    else $error("shifter ran while disabled");
  off_drop_a: assert property (wr_data && !on |=>
    count_q == $past(count_q))
    else $error("data queued while disabled");
  idle_pop_a: assert property (pop |=> state_q == SH_SHIFT)
    else $error("start did not begin shifting");
  result_hold_a: assert property (!step && !wr_result |=>
    $stable(result_q))
    else $error("result changed without a step");
  result_len_a: assert property (step |=>
    (result_q & ~$past(len_mask)) == 32'h0)
    else $error("result wider than polynomial");
  msb_shift_a: assert property (step && !lsb_first |=>
    shift_q == {$past(shift_q[30:0]), 1'b0})
    else $error("msb first shift wrong");
  bits_range_a: assert property (state_q == SH_SHIFT |->
    bits_q != '0 && bits_q <= BITS_W'(DATA_W))
    else $error("bit count out of range");
  irq_early_a: assert property (crc_irq && $past(isel) |->
    $past(empty))
    else $error("early interrupt while queue not empty");
  irq_late_a: assert property (crc_irq && !$past(isel) |->
    $past(empty) && $past(state_q == SH_IDLE))
    else $error("late interrupt before shifting ended");
  taps_write_a: assert property (
    wr_taps && sel_alias == ALIAS_BASE && avs_req.byteenable == 4'hf
    |=> taps_q == ($past(avs_req.writedata) & TAPS_WMASK))
    else $error("tap write not stored");
  alias_clr_a: assert property (
    wr_control && sel_alias == ALIAS_CLR && avs_req.byteenable == 4'hf
    |=> (control_q & $past(avs_req.writedata)) == 32'h0)
    else $error("clear alias left bits set");
  rsvd_zero_a: assert property (
    (control_q & ~CONTROL_WMASK) == 32'h0)
    else $error("unimplemented control bit set");

  fill_full_c: cover property (full && wr_data);
  abort_c: cover property (abort);
  irq_late_c: cover property (crc_irq && !isel);
  halt_c: cover property (state_q == SH_SHIFT && halt_in_idle && idle_mode);
  irq_early_c: cover property (crc_irq && isel);
endmodule

// *** tb/crc_bus_master.sv ***
// Avalon-MM master model standing in for the processor or DMA
`timescale 1ns/1ps
module crc_bus_master (
  input wire logic ref_clk,
  input wire logic waitrequest,
  output crc_pkg::avs_req_t req
);
  import crc_pkg::*;
  initial req = '0;
  // Request held until an edge with waitrequest low, then released
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    req <= '{read: !wr, write: wr, address: a, writedata: d,
             byteenable: 4'hf};
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    req <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d,
             byteenable: 4'h0};
  endtask
endmodule

// *** tb/programmable_crc_generator_tb_top.sv ***
// Self-checking testbench for the programmable CRC generator
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
  end end
module programmable_crc_generator_tb_top;
  import crc_pkg::*;
  localparam int WD[4] = '{7, 15, 31, 7};
  localparam int PL[4] = '{7, 15, 31, 4};
  localparam int CAP[4] = '{16, 8, 4, 16};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic idle_mode = 1'b0;
  avs_req_t avs_req;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic crc_irq;
  int failures = 0;
  int samples_checked = 0;
  int dly[4];
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'h0000_0026;
  logic [31:0] exp_v;

  programmable_crc_generator i_programmable_crc_generator (
    .ref_clk(ref_clk), .reset(reset), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .idle_mode(idle_mode), .crc_irq(crc_irq));
  crc_bus_master i_bus (.ref_clk(ref_clk),
    .waitrequest(avs_waitrequest), .req(avs_req));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Oldest expectation checked as each read completes
  always @(posedge ref_clk) begin
    if (!reset && avs_req.read && avs_waitrequest === 1'b0) begin
      exp_v = exp_q.pop_front();
      `CHK(avs_readdata, exp_v)
    end
  end

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] crc_word(input logic [31:0] r, w, t,
      input int wd, pl, input logic lsb, alt);
    logic in, fb;
    for (int i = 0; i <= wd; i++) begin
      in = lsb ? w[i] : w[wd - i];
      fb = alt ? r[pl] : in ^ r[pl];
      r = ((r << 1) | {31'h0, alt ? in : fb}) ^ (fb ? t : 32'h0);
      r = r & (ALL_ONES >> (31 - pl));
    end
    return r;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_bus.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_bus.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq(output int d);
    d = 0;
    @(negedge ref_clk);
    while (crc_irq !== 1'b1 && d < 3000) begin
      @(negedge ref_clk);
      d++;
    end
    if (d >= 3000) begin
      failures++;
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] c, t, r;
    logic lsb, alt;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0000_0040);
    rd(8'h10, 32'h0);
    wr(8'h00, ALL_ONES);
    rd(8'h00, 32'h1f1f_a07c);
    wr(8'h04, ALL_ONES);
    rd(8'h00, 32'h0000_0040);
    wr(8'h08, 32'h0000_8000);
    rd(8'h0c, 32'h0000_8040);
    wr(8'h0c, 32'h0000_8000);
    rd(8'h00, 32'h0000_0040);
    rd(8'h44, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      lsb = 1'(k % 2);
      alt = 1'(k / 2 % 2);
      c = 32'(WD[k]) << WIDTH_LO | 32'(PL[k]) << POLY_LENGTH_MINUS_ONE_LO | 32'h8000
          | 32'(k == 3) << ISEL_BIT | 32'(lsb) << LSB_BIT
          | 32'(alt) << MODE_BIT;
      rnd = next_rnd(rnd);
      t = rnd;
      wr(8'h00, c);
      wr(8'h10, t);
      rd(8'h10, t & 32'hffff_fffe);
      wr(8'h30, 32'h0);
      r = 32'h0;
      for (int i = 0; i < CAP[k]; i++) begin
        rnd = next_rnd(rnd);
        wr(8'h20, rnd);
        r = crc_word(r, rnd, t & 32'hffff_fffe, WD[k], PL[k], lsb, alt);
      end
      wr(8'h20, ~rnd);
      rd(8'h00, c | 32'(CAP[k]) << VCNT_LO | 32'h80);
      wr(8'h08, 32'h10);
      wait_irq(dly[k]);
      repeat (WD[k] + 4) @(posedge ref_clk);
      rd(8'h30, r);
      rd(8'h00, c | 32'h50);
      wr(8'h04, 32'h10);
      $display("test crc %0d done", k);
    end
    `CHK(dly[0] - dly[3] >= 7, 1'b1)
    c = 32'h0700_a000;
    wr(8'h00, c);
    rnd = next_rnd(rnd);
    wr(8'h20, rnd);
    idle_mode <= 1'b1;
    wr(8'h08, 32'h10);
    repeat (20) @(posedge ref_clk);
    rd(8'h00, c | 32'h110);
    idle_mode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    idle_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    idle_mode <= 1'b0;
    wait_irq(dly[0]);
    rd(8'h00, c | 32'h50);
    r = crc_word(r, rnd, t & 32'hffff_fffe, 7, 0, 1'b0, 1'b0);
    rd(8'h30, r);
    wr(8'h20, rnd);
    wr(8'h04, 32'h10);
    rd(8'h00, c | 32'h40);
    wr(8'h04, 32'h8000);
    wr(8'h20, rnd);
    rd(8'h00, 32'h0700_2040);
    rd(8'h20, rnd);
    $display("test idle done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    summarize();
  end
endmodule
